// file: design/etp_pkg.sv
package etp_pkg;

  // frame geometry of the outbound e3 frame
  localparam int unsigned ETP_FRAME_BITS = 1536;
  localparam int unsigned ETP_POS_W = 11;
  localparam logic [ETP_POS_W-1:0] ETP_POS_FIRST = 11'h000;
  localparam logic [ETP_POS_W-1:0] ETP_POS_LAST = 11'h5FF;
  localparam logic [ETP_POS_W-1:0] ETP_POS_STEP = 11'h001;
  // overhead bits open each frame: positions 0 .. 11
  localparam logic [ETP_POS_W-1:0] ETP_OH_BITS = 11'h00C;

  // nibble sample clock phase counter
  localparam int unsigned ETP_NIB_PH_W = 2;
  localparam logic [ETP_NIB_PH_W-1:0] ETP_NIB_PH_STEP = 2'h1;
  localparam logic [ETP_NIB_PH_W-1:0] ETP_NIB_PH_RISE = 2'h2;
  localparam int unsigned ETP_NIB_W = 4;

  // register bus, byte addresses, one aligned word each
  localparam int unsigned ETP_ADDR_W = 4;
  localparam logic [ETP_ADDR_W-1:0] ETP_CTRL_ADDR = 4'h0;
  localparam logic [ETP_ADDR_W-1:0] ETP_STATUS_ADDR = 4'h4;
  localparam logic [ETP_ADDR_W-1:0] ETP_FRAMES_ADDR = 4'h8;

  // control register fields
  localparam int unsigned ETP_CTRL_LOOP_BIT = 0;
  localparam int unsigned ETP_CTRL_MASTER_BIT = 1;
  localparam int unsigned ETP_CTRL_ENABLE_BIT = 2;
  localparam int unsigned ETP_CTRL_W = 3;
  localparam logic [ETP_CTRL_W-1:0] ETP_CTRL_RESET = 3'h5;

  // status register fields
  localparam int unsigned ETP_STAT_POS_LSB = 0;
  localparam int unsigned ETP_STAT_MODE_LSB = 16;
  localparam int unsigned ETP_FRAMES_W = 16;

  typedef struct packed {
    logic enable;
    logic master;
    logic loop;
  } etp_cfg_t;

  // the six interface modes as reported in status
  typedef enum logic [2:0] {
    ETP_MODE_SER_LOOP = 3'b001,
    ETP_MODE_SER_SLAVE = 3'b010,
    ETP_MODE_SER_MASTER = 3'b011,
    ETP_MODE_NIB_LOOP = 3'b100,
    ETP_MODE_NIB_SLAVE = 3'b101,
    ETP_MODE_NIB_MASTER = 3'b110
  } etp_mode_t;

  typedef enum logic {
    ETP_BUS_IDLE = 1'b0,
    ETP_BUS_ACK = 1'b1
  } etp_bus_state_t;

endpackage

// file: design/etp_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for pins from outside the core clock
module etp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: design/etp_pos_counter.sv
`timescale 1ns/1ps
// bit position within the frame, advanced once per bit period
module etp_pos_counter
  import etp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic bit_tick,
  input wire logic restart,
  output logic [ETP_POS_W-1:0] pos_reg,
  output logic [ETP_POS_W-1:0] pos_next
);

  // restart wins over wrap so a slave frame edge lands on bit 0
  always_comb begin
    if (restart || pos_reg == ETP_POS_LAST) begin
      pos_next = ETP_POS_FIRST;
    end else begin
      pos_next = pos_reg + ETP_POS_STEP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pos_reg <= ETP_POS_LAST;
    end else if (bit_tick) begin
      pos_reg <= pos_next;
    end
  end

endmodule

// file: design/etp_tx_payload_if.sv
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module etp_tx_payload_if
  import etp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ETP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic recovered_line_clock,
  input wire logic tx_local_timing_clock,
  input wire logic nibble_mode_select,
  input wire logic tx_serial_payload_in,
  input wire logic [ETP_NIB_W-1:0] tx_nibble_payload_in,
  input wire logic tx_frame_start_ref,
  output logic loop_timed_clock_out,
  output logic tx_nibble_sample_clock,
  output logic tx_overhead_warning,
  output logic tx_end_of_frame_pulse,
  output logic tx_payload_bit,
  output logic tx_payload_bit_valid,
  output logic [ETP_NIB_W-1:0] tx_payload_nibble,
  output logic tx_payload_nibble_valid
);

  localparam int unsigned SYNC_W = 5 + ETP_NIB_W;
  localparam logic [ETP_FRAMES_W-1:0] FRAMES_STEP = 16'h0001;

  logic [SYNC_W-1:0] pins_sync;
  logic line_clk_s;
  logic local_clk_s;
  logic nib_mode_s;
  logic ser_s;
  logic ref_s;
  logic [ETP_NIB_W-1:0] nib_s;
  etp_cfg_t cfg_reg;
  etp_bus_state_t bus_reg;
  logic timing_clk;
  logic timing_prev_reg;
  logic bit_tick;
  logic ref_prev_reg;
  logic restart_pend_reg;
  logic restart;
  logic frame_master;
  logic [ETP_POS_W-1:0] pos_reg;
  logic [ETP_POS_W-1:0] pos_next;
  logic [ETP_NIB_PH_W-1:0] nib_ph_reg;
  logic [ETP_NIB_PH_W-1:0] nib_ph_next;
  logic [ETP_FRAMES_W-1:0] frames_reg;
  etp_mode_t mode;
  logic [31:0] rd_next;

  // every pin from the far end crosses into core_clk here
  etp_sync #(.W(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({recovered_line_clock, tx_local_timing_clock,
               nibble_mode_select, tx_serial_payload_in,
               tx_frame_start_ref, tx_nibble_payload_in}),
    .sync_out(pins_sync)
  );

  assign {line_clk_s, local_clk_s, nib_mode_s, ser_s, ref_s, nib_s} =
    pins_sync;

  // timing reference select; local clock is dead in loop timing
  assign timing_clk = cfg_reg.loop ? line_clk_s : local_clk_s;

  // loop timing has no slave choice, so it always free-runs
  assign frame_master = cfg_reg.loop | cfg_reg.master;

  // rising edge of the chosen reference marks one bit period.
  // limitation: a 34.368 MHz reference is only resolved when the
  // core clock is fast enough; at 40 MHz edges can be missed.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timing_prev_reg <= 1'b0;
    end else begin
      timing_prev_reg <= timing_clk;
    end
  end

  assign bit_tick = cfg_reg.enable & timing_clk & ~timing_prev_reg;

  // frame reference edge held until the next bit period takes it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ref_prev_reg <= 1'b0;
      restart_pend_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_s;
      if (frame_master || !cfg_reg.enable) begin
        restart_pend_reg <= 1'b0;
      end else if (ref_s && !ref_prev_reg) begin
        restart_pend_reg <= 1'b1;
      end else if (bit_tick) begin
        restart_pend_reg <= 1'b0;
      end
    end
  end

  assign restart = restart_pend_reg & ~frame_master;

  etp_pos_counter u_pos (
    .core_clk(core_clk),
    .nrst(nrst),
    .bit_tick(bit_tick),
    .restart(restart),
    .pos_reg(pos_reg),
    .pos_next(pos_next)
  );

  // frame and overhead indicators, each updated once per bit period
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_overhead_warning <= 1'b0;
      tx_end_of_frame_pulse <= 1'b0;
    end else if (!cfg_reg.enable) begin
      tx_overhead_warning <= 1'b0;
      tx_end_of_frame_pulse <= 1'b0;
    end else if (bit_tick) begin
      tx_end_of_frame_pulse <= (pos_next == ETP_POS_LAST);
      // warn while the bit after the one now starting is overhead
      tx_overhead_warning <= (pos_next == ETP_POS_LAST) ||
        ((pos_next + ETP_POS_STEP) < ETP_OH_BITS);
    end
  end

  // serial sampling, skipping overhead slots
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_payload_bit <= 1'b0;
      tx_payload_bit_valid <= 1'b0;
    end else begin
      tx_payload_bit_valid <= 1'b0;
      if (bit_tick && !nib_mode_s && pos_next >= ETP_OH_BITS) begin
        tx_payload_bit <= ser_s;
        tx_payload_bit_valid <= 1'b1;
      end
    end
  end

  // nibble clock: two bit periods high, two low, from the reference
  assign nib_ph_next = nib_ph_reg + ETP_NIB_PH_STEP;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      nib_ph_reg <= '0;
      tx_nibble_sample_clock <= 1'b0;
    end else if (!nib_mode_s || !cfg_reg.enable) begin
      nib_ph_reg <= '0;
      tx_nibble_sample_clock <= 1'b0;
    end else if (bit_tick) begin
      nib_ph_reg <= nib_ph_next;
      tx_nibble_sample_clock <= nib_ph_next[ETP_NIB_PH_W-1];
    end
  end

  // nibble taken on the same edge the sample clock rises
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_payload_nibble <= '0;
      tx_payload_nibble_valid <= 1'b0;
    end else begin
      tx_payload_nibble_valid <= 1'b0;
      if (bit_tick && nib_mode_s && cfg_reg.enable &&
          nib_ph_next == ETP_NIB_PH_RISE) begin
        tx_payload_nibble <= nib_s;
        tx_payload_nibble_valid <= 1'b1;
      end
    end
  end

  // clock handed to the far end in loop timing only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      loop_timed_clock_out <= 1'b0;
    end else begin
      loop_timed_clock_out <= cfg_reg.loop & cfg_reg.enable &
        line_clk_s;
    end
  end

  // completed frames, wraps silently
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      frames_reg <= '0;
    end else if (bit_tick && pos_next == ETP_POS_LAST) begin
      frames_reg <= frames_reg + FRAMES_STEP;
    end
  end

  // current mode for status readback
  always_comb begin
    if (cfg_reg.loop) begin
      mode = nib_mode_s ? ETP_MODE_NIB_LOOP : ETP_MODE_SER_LOOP;
    end else if (cfg_reg.master) begin
      mode = nib_mode_s ? ETP_MODE_NIB_MASTER : ETP_MODE_SER_MASTER;
    end else begin
      mode = nib_mode_s ? ETP_MODE_NIB_SLAVE : ETP_MODE_SER_SLAVE;
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_next = '0;
    case (avs_address)
      ETP_CTRL_ADDR: begin
        rd_next[ETP_CTRL_W-1:0] = cfg_reg;
      end
      ETP_STATUS_ADDR: begin
        rd_next[ETP_STAT_POS_LSB +: ETP_POS_W] = pos_reg;
        rd_next[ETP_STAT_MODE_LSB +: $bits(etp_mode_t)] = mode;
      end
      ETP_FRAMES_ADDR: begin
        rd_next[ETP_FRAMES_W-1:0] = frames_reg;
      end
      default: begin
        rd_next = '0;
      end
    endcase
  end

  // one wait cycle per access keeps readdata a clean register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus_reg <= ETP_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      case (bus_reg)
        ETP_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_reg <= ETP_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_next : '0;
          end
        end
        ETP_BUS_ACK: begin
          bus_reg <= ETP_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_reg <= ETP_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // control register written on the accepting edge only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_reg <= ETP_CTRL_RESET;
    end else if (bus_reg == ETP_BUS_ACK && avs_write &&
                 avs_address == ETP_CTRL_ADDR) begin
      cfg_reg <= avs_writedata[ETP_CTRL_W-1:0];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_last_bit;
    bit_tick && pos_next == ETP_POS_LAST;
  endsequence

  sequence s_next_tick;
    bit_tick;
  endsequence

  a_eof_on_last: assert property (
    s_last_bit |=> tx_end_of_frame_pulse)
    else $error("end of frame missing on last bit");

  a_eof_one_bit: assert property (
    tx_end_of_frame_pulse ##0 s_next_tick |=> !tx_end_of_frame_pulse)
    else $error("end of frame held past one bit");

  a_warn_before_oh: assert property (
    s_last_bit |=> tx_overhead_warning && pos_reg == ETP_POS_LAST)
    else $error("overhead warning missing before frame");

  a_warn_into_pay: assert property (
    bit_tick && pos_next == ETP_OH_BITS - ETP_POS_STEP |=>
      !tx_overhead_warning)
    else $error("overhead warning on payload bit");

  a_oh_ser_skip: assert property (
    bit_tick && pos_next < ETP_OH_BITS |=> !tx_payload_bit_valid)
    else $error("serial bit taken in overhead slot");

  a_ser_mode_only: assert property (
    tx_payload_bit_valid |-> !$past(nib_mode_s))
    else $error("serial bit taken in nibble mode");

  a_nib_on_rise: assert property (
    $rose(tx_nibble_sample_clock) |-> tx_payload_nibble_valid)
    else $error("nibble not sampled on clock rise");

  a_slave_restart: assert property (
    restart && bit_tick |=> pos_reg == ETP_POS_FIRST)
    else $error("frame reference did not restart frame");

  a_loop_clk_off: assert property (
    !cfg_reg.loop |=> !loop_timed_clock_out)
    else $error("loop clock driven out of loop timing");

  a_nib_serial_off: assert property (
    !nib_mode_s |=> !tx_payload_nibble_valid)
    else $error("nibble taken in serial mode");

  a_nib_clk_idle: assert property (
    !nib_mode_s |=> !tx_nibble_sample_clock)
    else $error("nibble clock running in serial mode");

  a_bus_answer: assert property (
    (avs_read || avs_write) && bus_reg == ETP_BUS_IDLE |=>
      !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule

// file: sim/etp_term_model.sv
`timescale 1ns/1ps
// terminal equipment: timing clocks, payload pins and frame reference
module etp_term_model (
  input wire logic core_clk,
  input wire logic ser_val,
  input wire logic ref_go,
  input wire logic [3:0] nib_val,
  input wire logic eof,
  output logic recovered_line_clock,
  output logic tx_local_timing_clock,
  output logic tx_serial_payload_in,
  output logic [3:0] tx_nibble_payload_in,
  output logic tx_frame_start_ref
);
  logic [1:0] line_cnt;
  logic [2:0] loc_cnt;

  initial begin
    line_cnt = 2'h0;
    loc_cnt = 3'h0;
    recovered_line_clock = 1'b0;
    tx_local_timing_clock = 1'b0;
    tx_serial_payload_in = 1'b0;
    tx_nibble_payload_in = 4'h0;
    tx_frame_start_ref = 1'b0;
  end

  // clocks well below core rate so the design's sampling never misses edges
  always @(posedge core_clk) begin
    line_cnt <= line_cnt + 2'h1;
    loc_cnt <= (loc_cnt == 3'h5) ? 3'h0 : loc_cnt + 3'h1;
    recovered_line_clock <= line_cnt[1];
    tx_local_timing_clock <= (loc_cnt > 3'h2);
  end

  // a new serial payload value is only started once a frame has ended; nibble and frame reference follow each cycle
  always @(posedge core_clk) begin
    if (eof) begin
      tx_serial_payload_in <= ser_val;
    end
    tx_frame_start_ref <= ref_go;
    tx_nibble_payload_in <= nib_val;
  end
endmodule

// file: sim/etp_tx_payload_if_test.sv
`timescale 1ns/1ps
module etp_tx_payload_if_test;
  import etp_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ETP_ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic recovered_line_clock, tx_local_timing_clock, tx_serial_payload_in;
  logic [3:0] tx_nibble_payload_in;
  logic tx_frame_start_ref, loop_timed_clock_out, tx_nibble_sample_clock;
  logic tx_overhead_warning, tx_end_of_frame_pulse;
  logic tx_payload_bit, tx_payload_bit_valid;
  logic [3:0] tx_payload_nibble;
  logic tx_payload_nibble_valid;
  logic nibble_mode_select = 1'b0;
  logic ser_val = 1'b1;
  logic ref_go = 1'b0;
  logic [3:0] nib_val = 4'hA;
  logic chk = 1'b0;
  logic eof_q = 1'b0, lo_q = 1'b0, nk_q = 1'b0;
  logic [31:0] d;
  int failures = 0, n_tests = 0, nfr = 0;
  int wc = 0, ec = 0, bv = 0, nv = 0, lr = 0, kr = 0;
  int s_wc, s_ec, s_bv, s_nv, s_lr, s_kr;

  always #12.5 core_clk = ~core_clk;

  etp_tx_payload_if etp_tx_payload_if_i (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .recovered_line_clock(recovered_line_clock),
    .tx_local_timing_clock(tx_local_timing_clock),
    .nibble_mode_select(nibble_mode_select),
    .tx_serial_payload_in(tx_serial_payload_in),
    .tx_nibble_payload_in(tx_nibble_payload_in),
    .tx_frame_start_ref(tx_frame_start_ref),
    .loop_timed_clock_out(loop_timed_clock_out),
    .tx_nibble_sample_clock(tx_nibble_sample_clock),
    .tx_overhead_warning(tx_overhead_warning),
    .tx_end_of_frame_pulse(tx_end_of_frame_pulse),
    .tx_payload_bit(tx_payload_bit),
    .tx_payload_bit_valid(tx_payload_bit_valid),
    .tx_payload_nibble(tx_payload_nibble),
    .tx_payload_nibble_valid(tx_payload_nibble_valid));

  etp_term_model etp_term_model_i (.core_clk(core_clk), .ser_val(ser_val),
    .ref_go(ref_go), .nib_val(nib_val), .eof(tx_end_of_frame_pulse),
    .recovered_line_clock(recovered_line_clock),
    .tx_local_timing_clock(tx_local_timing_clock),
    .tx_serial_payload_in(tx_serial_payload_in),
    .tx_nibble_payload_in(tx_nibble_payload_in),
    .tx_frame_start_ref(tx_frame_start_ref));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= wd;
    // no local limit: a hang is caught by the watchdog
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // frame monitor: counts per window between end-of-frame rises
  always @(posedge core_clk) begin
    eof_q <= tx_end_of_frame_pulse;
    lo_q <= loop_timed_clock_out;
    nk_q <= tx_nibble_sample_clock;
    if (tx_end_of_frame_pulse === 1'b1 && eof_q === 1'b0) begin
      s_wc = wc;
      s_ec = ec;
      s_bv = bv;
      s_nv = nv;
      s_lr = lr;
      s_kr = kr;
      wc = 0;
      ec = 0;
      bv = 0;
      nv = 0;
      lr = 0;
      kr = 0;
      nfr++;
    end
    wc += (tx_overhead_warning === 1'b1);
    ec += (tx_end_of_frame_pulse === 1'b1);
    bv += (tx_payload_bit_valid === 1'b1);
    nv += (tx_payload_nibble_valid === 1'b1);
    lr += (loop_timed_clock_out === 1'b1 && lo_q === 1'b0);
    kr += (tx_nibble_sample_clock === 1'b1 && nk_q === 1'b0);
    // every serial sample of the measured frame, last bit included
    if (chk && tx_payload_bit_valid === 1'b1)
      check(32'(tx_payload_bit), 32'(ser_val));
    if (chk && tx_payload_nibble_valid === 1'b1)
      check(32'(tx_payload_nibble), 32'(nib_val));
  end

  // one whole frame of p core cycles per bit period
  task automatic meas(input int p, input int ebv, input int enib,
                      input int elr);
    int t;
    t = nfr;
    wait (nfr != t);
    chk = 1'b1;
    t = nfr;
    wait (nfr != t);
    chk = 1'b0;
    check(32'(s_wc), 32'(12 * p));
    check(32'(s_ec), 32'(p));
    check(32'(s_bv), 32'(ebv));
    check(32'(s_nv), 32'(enib * 384));
    check(32'(s_kr), 32'(enib * 384));
    check(32'(s_lr), 32'(elr));
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    acc(1'b0, ETP_CTRL_ADDR, 32'h0, d);
    check(d, 32'h00000005);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_SER_LOOP));
    acc(1'b0, 4'hC, 32'h0, d);
    check(d, 32'h00000000);
    acc(1'b1, ETP_STATUS_ADDR, 32'hFFFFFFFF, d);
    acc(1'b0, ETP_CTRL_ADDR, 32'h0, d);
    check(d, 32'h00000005);
    // loop timing: bit period of the line clock, local clock ignored
    meas(4, 1524, 0, 1536);
    // frame counter must agree with end-of-frame pulses seen so far
    acc(1'b0, ETP_FRAMES_ADDR, 32'h0, d);
    check(d, 32'(nfr));
    ser_val <= 1'b0;
    acc(1'b1, ETP_CTRL_ADDR, 32'h00000006, d);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_SER_MASTER));
    meas(6, 1524, 0, 0);
    nibble_mode_select <= 1'b1;
    repeat (4) @(posedge core_clk);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_NIB_MASTER));
    meas(6, 0, 1, 0);
    // nibble clock now taken from the line clock under loop timing
    acc(1'b1, ETP_CTRL_ADDR, 32'h00000005, d);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_NIB_LOOP));
    meas(4, 0, 1, 1536);
    acc(1'b1, ETP_CTRL_ADDR, 32'h00000004, d);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_NIB_SLAVE));
    nibble_mode_select <= 1'b0;
    repeat (4) @(posedge core_clk);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[18:16]), 32'(ETP_MODE_SER_SLAVE));
    // slave: frame restarts at the next bit tick after the reference edge
    ref_go <= 1'b1;
    repeat (14) @(posedge core_clk);
    acc(1'b0, ETP_STATUS_ADDR, 32'h0, d);
    check(32'(d[10:0] < 11'h005), 32'h1);
    ref_go <= 1'b0;
    results;
  end

  // watchdog well beyond the expected run of about 62000 cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    failures++;
    results;
  end
endmodule
